//--- common/vtc_pkg.sv
// Constants shared by the tandem overhead source block
`default_nettype none
package vtc_pkg;
  // Stream layout: byte positions counted from the frame start byte
  localparam logic [9:0] FRAME_BYTES = 10'h2fd;
  localparam logic [9:0] POS_B3 = 10'h055;
  localparam logic [9:0] POS_N1 = 10'h2a8;
  // Multiframe on N1 bits 7 and 8
  localparam logic [6:0] MF_LEN = 7'h4c;
  localparam logic [6:0] MF_FAS_LAST = 7'h08;
  localparam logic [6:0] MF_TI_FIRST = 7'h09;
  localparam logic [6:0] MF_TI_LAST = 7'h48;
  localparam logic [6:0] MF_RDI = 7'h49;
  localparam logic [6:0] MF_ODI = 7'h4a;
  localparam logic [11:0] FAS_WORD = 12'hffe;
  localparam logic [3:0] FAS_LEAD = 4'hf;
  localparam int TRACE_BITS = 128;
  // Error code field
  localparam logic [3:0] IEC_ZERO = 4'h9;
  localparam logic [3:0] IEC_AIS = 4'he;
  // Timing: indications must appear within this limit
  localparam int LIMIT_MS = 20;
  localparam int FRAME_US = 125;
  localparam int MF_PERIOD_US = 9500;
  localparam int LIMIT_FRAMES = (LIMIT_MS * 1000) / FRAME_US;
  // Register map (byte addresses)
  localparam logic [7:0] REG_TRACE0 = 8'h00;
  localparam logic [7:0] REG_TRACE1 = 8'h04;
  localparam logic [7:0] REG_TRACE2 = 8'h08;
  localparam logic [7:0] REG_TRACE3 = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int STATUS_BITS = 12;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : vtc_pkg
`default_nettype wire

//--- common/vtc_cdc_if.sv
// Word crossing bundle between the block and its handshake synchroniser
`default_nettype none
interface vtc_cdc_if #(parameter int W = 8);
  logic load;
  logic [W-1:0] src_data;
  logic busy;
  logic [W-1:0] dst_data;
  logic update;
  modport xfer (input load, input src_data, output busy, output dst_data, output update);
  modport user (output load, output src_data, input busy, input dst_data, input update);
endinterface : vtc_cdc_if
`default_nettype wire

//--- logic/vtc_cdc.sv
// Toggle handshake that carries one word from a source to a destination clock
`default_nettype none
module vtc_cdc #(
  parameter int W = 8
) (
  // Source domain
  input wire logic i_src_clk,
  input wire logic i_src_rst,
  // Destination domain
  input wire logic i_dst_clk,
  input wire logic i_dst_rst,
  // Bundle
  vtc_cdc_if.xfer x
);
  logic [W-1:0] hold;
  logic req;
  logic ack_s1;
  logic ack_s2;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic ack;

  // Data held steady while the request toggle is in flight
  always_ff @(posedge i_src_clk or posedge i_src_rst) begin
    if (i_src_rst) begin
      hold <= '0;
      req <= 1'b0;
    end else if (x.load && !x.busy) begin
      hold <= x.src_data;
      req <= ~req;
    end
  end

  always_ff @(posedge i_src_clk or posedge i_src_rst) begin
    if (i_src_rst) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
    end
  end
  assign x.busy = req ^ ack_s2;

  always_ff @(posedge i_dst_clk or posedge i_dst_rst) begin
    if (i_dst_rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  always_ff @(posedge i_dst_clk or posedge i_dst_rst) begin
    if (i_dst_rst) begin
      x.dst_data <= '0;
      x.update <= 1'b0;
      ack <= 1'b0;
    end else begin
      x.update <= req_s2 ^ req_s3;
      if (req_s2 ^ req_s3) begin
        x.dst_data <= hold;
        ack <= req_s2;
      end
    end
  end
endmodule : vtc_cdc
`default_nettype wire

//--- logic/vtc_iec.sv
// Parity violation count and its four-bit incoming error code
`default_nettype none
module vtc_iec (
  // Parity inputs
  input wire logic [7:0] i_bip,
  input wire logic [7:0] i_b3,
  // Code output
  output logic [3:0] o_code
);
  logic [7:0] diff;
  logic [3:0] count;

  assign diff = i_bip ^ i_b3;

  always_comb begin
    count = 4'h0;
    for (int k = 0; k < 8; k++) begin
      count = count + {3'h0, diff[k]};
    end
    // All-zero code is kept free so the far end can spot an unequipped link
    o_code = (count == 4'h0) ? vtc_pkg::IEC_ZERO : count;
  end
endmodule : vtc_iec
`default_nettype wire

//--- logic/vtc_source.sv
// Tandem overhead source: writes N1, recompensates B3, carries the multiframe
// Behaviour
// - Remote defect bit follows request within limit
// - Remote error input copied into N1 bit 5
// - Outgoing defect bit follows request within limit
// - Outgoing error input copied into N1 bit 6
// - Bits 7-8 form 76-frame multiframe
// - Alignment word sent in frames 1 to 8
// - Trace identifier sent in frames 9 to 72
// - Defect bits in 73/74, other reserved zero
// - Parity violation count placed in bits 1-4
// - Server fail forces code 1110
// - Zero violations never coded as all zeros
// - B3 recompensated from old and new bytes
// - Defect bit one means defect, zero normal
//
// The address map and strobed register access are this design's own decisions.
`default_nettype none
module vtc_source (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Stream from the adaptation side
  input wire logic i_vc_clock_in,
  input wire logic [7:0] i_vc_data_in,
  input wire logic i_vc_frame_start_in,
  input wire logic i_server_fail_in,
  // Indications from the local tandem sink
  input wire logic i_remote_defect_request,
  input wire logic i_remote_error_value,
  input wire logic i_outgoing_defect_request,
  input wire logic i_outgoing_error_value,
  // Stream to the connection point
  output logic o_vc_clock_out,
  output logic [7:0] o_vc_data_out,
  output logic o_vc_frame_start_out
);
  // Link domain reset, asserted at once, released on the link clock
  logic lrst_s1;
  logic lrst;

  always_ff @(posedge i_vc_clock_in or posedge i_rst) begin
    if (i_rst) begin
      lrst_s1 <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_s1 <= 1'b0;
      lrst <= lrst_s1;
    end
  end

  // Crossings
  vtc_cdc_if #(.W(vtc_pkg::TRACE_BITS)) trace_x ();
  vtc_cdc_if #(.W(vtc_pkg::STATUS_BITS)) stat_x ();

  vtc_cdc #(.W(vtc_pkg::TRACE_BITS)) u_trace_cdc (
    .i_src_clk(i_clk),
    .i_src_rst(i_rst),
    .i_dst_clk(i_vc_clock_in),
    .i_dst_rst(lrst),
    .x(trace_x.xfer)
  );

  vtc_cdc #(.W(vtc_pkg::STATUS_BITS)) u_stat_cdc (
    .i_src_clk(i_vc_clock_in),
    .i_src_rst(lrst),
    .i_dst_clk(i_clk),
    .i_dst_rst(i_rst),
    .x(stat_x.xfer)
  );

  // ---------------- System clock side: registers ----------------
  logic [31:0] trace_w [4];
  logic trace_pending;
  logic [vtc_pkg::STATUS_BITS-1:0] status;

  // One-hot select of the trace word an access hits
  logic [3:0] trace_sel;

  always_comb begin
    trace_sel = 4'h0;
    if (i_addr == vtc_pkg::REG_TRACE0) begin
      trace_sel = 4'h1;
    end else if (i_addr == vtc_pkg::REG_TRACE1) begin
      trace_sel = 4'h2;
    end else if (i_addr == vtc_pkg::REG_TRACE2) begin
      trace_sel = 4'h4;
    end else if (i_addr == vtc_pkg::REG_TRACE3) begin
      trace_sel = 4'h8;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_trace_word
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        trace_w[g] <= vtc_pkg::RESET_WORD;
      end else if (i_wr && trace_sel[g]) begin
        trace_w[g] <= i_wdata;
      end
    end
  end

  // A write during a crossing is held and sent afterwards, never dropped
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trace_pending <= 1'b1;
    end else if (i_wr && trace_sel != 4'h0) begin
      trace_pending <= 1'b1;
    end else if (!trace_x.busy) begin
      trace_pending <= 1'b0;
    end
  end

  assign trace_x.load = trace_pending;
  assign trace_x.src_data = {trace_w[0], trace_w[1], trace_w[2], trace_w[3]};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status <= '0;
    end else if (stat_x.update) begin
      status <= stat_x.dst_data;
    end
  end

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (!i_rd) begin
      next_rdata = '0;
    end else if (i_addr == vtc_pkg::REG_TRACE0) begin
      next_rdata = trace_w[0];
    end else if (i_addr == vtc_pkg::REG_TRACE1) begin
      next_rdata = trace_w[1];
    end else if (i_addr == vtc_pkg::REG_TRACE2) begin
      next_rdata = trace_w[2];
    end else if (i_addr == vtc_pkg::REG_TRACE3) begin
      next_rdata = trace_w[3];
    end else if (i_addr == vtc_pkg::REG_STATUS) begin
      next_rdata = {19'h0, trace_pending, status};
    end
  end

  // Read data stands one cycle only; zero keeps stale words off the bus
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ---------------- Link side ----------------
  // Sink indications come from another clock: two stages first
  logic [3:0] ri_s1;
  logic [3:0] ri;

  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      ri_s1 <= 4'h0;
      ri <= 4'h0;
    end else begin
      ri_s1 <= {i_remote_defect_request, i_remote_error_value,
                i_outgoing_defect_request, i_outgoing_error_value};
      ri <= ri_s1;
    end
  end

  logic [vtc_pkg::TRACE_BITS-1:0] trace;

  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      trace <= '0;
    end else if (trace_x.update) begin
      trace <= trace_x.dst_data;
    end
  end

  // Byte position and multiframe number
  logic [9:0] pos;
  logic [9:0] cur_pos;
  logic [6:0] mf;
  logic [6:0] next_mf;

  assign cur_pos = i_vc_frame_start_in ? 10'h000 : pos + 10'h001;
  assign next_mf = (mf == vtc_pkg::MF_LEN) ? 7'h01 : mf + 7'h01;

  // Overhead byte strobes, one link cycle each
  logic at_b3;
  logic at_n1;

  assign at_b3 = (cur_pos == vtc_pkg::POS_B3);
  assign at_n1 = (cur_pos == vtc_pkg::POS_N1);

  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      pos <= vtc_pkg::FRAME_BYTES;
    end else if (i_vc_frame_start_in || pos != vtc_pkg::FRAME_BYTES) begin
      pos <= cur_pos;
    end
  end

  // Reset value makes the first frame number one
  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      mf <= vtc_pkg::MF_LEN;
    end else if (i_vc_frame_start_in) begin
      mf <= next_mf;
    end
  end

  // Parity over every received byte of the frame, B3 included
  logic [7:0] bip_acc;
  logic [7:0] bip_prev;

  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      bip_acc <= 8'h00;
    end else if (i_vc_frame_start_in) begin
      bip_acc <= i_vc_data_in;
    end else begin
      bip_acc <= bip_acc ^ i_vc_data_in;
    end
  end

  // Whole previous frame, as received, is held against this frame's B3
  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      bip_prev <= 8'h00;
    end else if (i_vc_frame_start_in) begin
      bip_prev <= bip_acc;
    end
  end

  logic [3:0] iec_code;
  logic [3:0] iec;

  vtc_iec u_iec (
    .i_bip(bip_prev),
    .i_b3(i_vc_data_in),
    .o_code(iec_code)
  );

  // Code taken when B3 arrives, inserted later in the same frame's N1
  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      iec <= vtc_pkg::IEC_ZERO;
    end else if (at_b3) begin
      iec <= iec_code;
    end
  end

  // Multiframed bits 7 and 8 for the current frame
  logic [1:0] mf_bits;
  logic [15:0] fas_full;
  logic [6:0] ti_idx;
  logic [7:0] n1_new;

  assign fas_full = {vtc_pkg::FAS_LEAD, vtc_pkg::FAS_WORD};
  assign ti_idx = mf - vtc_pkg::MF_TI_FIRST;

  always_comb begin
    mf_bits = 2'b00;
    if (mf <= vtc_pkg::MF_FAS_LAST) begin
      mf_bits = fas_full[5'd17 - {mf[3:0], 1'b0} -: 2];
    end else if (mf <= vtc_pkg::MF_TI_LAST) begin
      mf_bits = trace[8'd127 - {ti_idx[5:0], 1'b0} -: 2];
    end else if (mf == vtc_pkg::MF_RDI) begin
      mf_bits = {1'b0, ri[3]};
    end else if (mf == vtc_pkg::MF_ODI) begin
      mf_bits = {ri[1], 1'b0};
    end
  end

  // N1 bit 1 is the most significant bit of the byte
  assign n1_new = {(i_server_fail_in ? vtc_pkg::IEC_AIS : iec),
                   ri[2],
                   ri[0],
                   mf_bits};

  // Previous frame's B3 and N1, before and after rewriting
  logic [7:0] b3_in_prev;
  logic [7:0] b3_out_prev;
  logic [7:0] n1_in_prev;
  logic [7:0] n1_out_prev;
  logic [7:0] b3_new;

  assign b3_new = b3_in_prev ^ b3_out_prev ^ n1_in_prev ^ n1_out_prev ^ i_vc_data_in;

  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      b3_in_prev <= 8'h00;
      b3_out_prev <= 8'h00;
    end else if (at_b3) begin
      b3_in_prev <= i_vc_data_in;
      b3_out_prev <= b3_new;
    end
  end

  // N1 as received and as written, kept for next frame's compensation
  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      n1_in_prev <= 8'h00;
      n1_out_prev <= 8'h00;
    end else if (at_n1) begin
      n1_in_prev <= i_vc_data_in;
      n1_out_prev <= n1_new;
    end
  end

  // One byte of delay; frame start moves with its byte
  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      o_vc_frame_start_out <= 1'b0;
    end else begin
      o_vc_frame_start_out <= i_vc_frame_start_in;
    end
  end

  always_ff @(posedge i_vc_clock_in or posedge lrst) begin
    if (lrst) begin
      o_vc_data_out <= 8'h00;
    end else if (at_b3) begin
      o_vc_data_out <= b3_new;
    end else if (at_n1) begin
      o_vc_data_out <= n1_new;
    end else begin
      o_vc_data_out <= i_vc_data_in;
    end
  end

  assign o_vc_clock_out = i_vc_clock_in;

  // Status snapshot once a frame; a busy crossing skips a frame, harmless
  assign stat_x.load = i_vc_frame_start_in;
  assign stat_x.src_data = {i_server_fail_in, iec, next_mf};
endmodule : vtc_source
`default_nettype wire

//--- bench/vtc_source_monitor.sv
// Checker for the stream side of the tandem overhead source
`default_nettype none
module vtc_source_monitor (
  // Link clock and reset
  input wire logic i_vc_clock_in,
  input wire logic i_rst,
  // Stream and indications in
  input wire logic [7:0] i_vc_data_in,
  input wire logic i_vc_frame_start_in,
  input wire logic i_server_fail_in,
  input wire logic i_remote_defect_request,
  input wire logic i_remote_error_value,
  input wire logic i_outgoing_defect_request,
  input wire logic i_outgoing_error_value,
  // Stream out
  input wire logic [7:0] o_vc_data_out,
  input wire logic o_vc_frame_start_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] cnt;
  logic [9:0] pos;
  logic [6:0] mf;
  // Position stays at all ones until the first frame start
  assign pos = i_vc_frame_start_in ? 10'h000 : (cnt == 10'h3ff ? cnt : cnt + 10'h001);
  always_ff @(posedge i_vc_clock_in or posedge i_rst) begin
    if (i_rst) cnt <= 10'h3ff;
    else cnt <= pos;
  end
  always_ff @(posedge i_vc_clock_in or posedge i_rst) begin
    if (i_rst) mf <= 7'h00;
    else if (i_vc_frame_start_in) mf <= (mf == vtc_pkg::MF_LEN) ? 7'h01 : mf + 7'h01;
  end
  default clocking dc @(posedge i_vc_clock_in); endclocking
  default disable iff (i_rst);
  sequence s_n1;
    pos == vtc_pkg::POS_N1;
  endsequence
  property p_fs_delay;
    i_vc_frame_start_in |=> o_vc_frame_start_out;
  endproperty
  a_fs_delay: assert property (p_fs_delay) else $error("frame start not delayed");
  property p_pass;
    pos != 10'h3ff && pos != vtc_pkg::POS_B3 && pos != vtc_pkg::POS_N1
      |=> o_vc_data_out == $past(i_vc_data_in);
  endproperty
  a_pass: assert property (p_pass) else $error("payload byte altered");
  property p_sf;
    s_n1 ##0 i_server_fail_in |=> o_vc_data_out[7:4] == vtc_pkg::IEC_AIS;
  endproperty
  a_sf: assert property (p_sf) else $error("no incoming AIS code");
  property p_iec_nz;
    s_n1 |=> o_vc_data_out[7:4] != 4'h0;
  endproperty
  a_iec_nz: assert property (p_iec_nz) else $error("error code all zeros");
  property p_iec_range;
    s_n1 ##0 !i_server_fail_in |=> o_vc_data_out[7:4] inside {[4'h1:4'h9]};
  endproperty
  a_iec_range: assert property (p_iec_range) else $error("error code out of range");
  property p_fas;
    s_n1 ##0 (mf >= 7'h01 && mf <= vtc_pkg::MF_FAS_LAST)
      |=> o_vc_data_out[1:0] == ((mf == vtc_pkg::MF_FAS_LAST) ? 2'b10 : 2'b11);
  endproperty
  a_fas: assert property (p_fas) else $error("alignment bits wrong");
  property p_reserved;
    s_n1 ##0 mf > vtc_pkg::MF_TI_LAST
      |=> !(o_vc_data_out[1] && mf != vtc_pkg::MF_ODI) && !(o_vc_data_out[0] && mf != vtc_pkg::MF_RDI);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_rdi;
    s_n1 ##0 mf == vtc_pkg::MF_RDI |=> o_vc_data_out[0] == i_remote_defect_request;
  endproperty
  a_rdi: assert property (p_rdi) else $error("remote defect bit wrong");
  property p_odi;
    s_n1 ##0 mf == vtc_pkg::MF_ODI |=> o_vc_data_out[1] == i_outgoing_defect_request;
  endproperty
  a_odi: assert property (p_odi) else $error("outgoing defect bit wrong");
  property p_rei;
    $stable({i_remote_error_value, i_outgoing_error_value})[*8] ##0 s_n1
      |=> o_vc_data_out[3:2] == $past({i_remote_error_value, i_outgoing_error_value});
  endproperty
  a_rei: assert property (p_rei) else $error("error indication bits wrong");
endmodule : vtc_source_monitor
bind vtc_source vtc_source_monitor u_vtc_source_monitor (.*);
`default_nettype wire

//--- bench/vtc_far_sink.sv
// Far-end tandem sink model: picks the overhead bytes out of each frame
`default_nettype none
module vtc_far_sink (
  // Stream in
  input wire logic i_clk,
  input wire logic i_fs,
  input wire logic [7:0] i_data,
  // Captured overhead
  output logic o_done,
  output logic [7:0] o_n1,
  output logic [7:0] o_b3
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] pos;
  // No reset: alignment comes from the first frame start, as in the field
  always_ff @(posedge i_clk) begin
    pos <= i_fs ? 10'h001 : pos + 10'h001;
    o_done <= !i_fs && pos == vtc_pkg::POS_N1;
    if (!i_fs && pos == vtc_pkg::POS_B3) o_b3 <= i_data;
    if (!i_fs && pos == vtc_pkg::POS_N1) o_n1 <= i_data;
  end
endmodule : vtc_far_sink
`default_nettype wire

//--- bench/test_vtc_source.sv
// Self-checking bench for the tandem overhead source
`default_nettype none
module test_vtc_source;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst = 1, lk = 0, wr = 0, rd = 0, fs = 0, sf = 0, rd_d = 0;
  logic rdi = 1, odi = 0, rei = 0, oei = 0, ck_o, fs_o, done;
  logic [7:0] addr = 0, d_in = 0, d_o, n1_o, b3_o;
  logic [31:0] wd = 0, rdata;
  logic [15:0] note;
  logic [15:0] note_q[$];
  logic [31:0] rq[$];
  logic [127:0] trace;
  int fails = 0, tests_run = 0;
  always #5 i_clk = ~i_clk;
  always #6 lk = ~lk;
  vtc_source u_vtc_source (.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_vc_clock_in(lk), .i_vc_data_in(d_in),
    .i_vc_frame_start_in(fs), .i_server_fail_in(sf), .i_remote_defect_request(rdi),
    .i_remote_error_value(rei), .i_outgoing_defect_request(odi),
    .i_outgoing_error_value(oei), .o_vc_clock_out(ck_o), .o_vc_data_out(d_o),
    .o_vc_frame_start_out(fs_o));
  vtc_far_sink u_vtc_far_sink (.i_clk(ck_o), .i_fs(fs_o), .i_data(d_o), .o_done(done),
    .o_n1(n1_o), .o_b3(b3_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= d;
    @(posedge i_clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  always @(posedge i_clk) begin
    rd_d <= rd;
    if (rd_d) check(rdata, rq.pop_front());
  end
  always @(posedge lk) begin
    if (done === 1'b1) begin
      if (note_q.size() == 0) check(32'h0, 32'h1);
      else begin
        note = note_q.pop_front();
        check({24'h0, n1_o}, {24'h0, note[15:8]});
        check({24'h0, b3_o}, {24'h0, note[7:0]});
      end
    end
  end
  initial begin
    #900000;
    fails++;
    wrap_up();
  end
  initial begin
    logic [7:0] par, pp, b3p, b3op, n1p, n1op, b3, bt, n1x, b3x;
    logic [3:0] iec, code;
    logic [1:0] mfb;
    logic sfn;
    logic [31:0] st;
    int m, cnt;
    void'($urandom(70422));
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    trace = {$urandom, $urandom, $urandom, $urandom};
    for (int w = 0; w < 4; w++) bus(1'b1, 8'(4 * w), trace[127 - 32 * w -: 32]);
    rq.push_back(trace[127:96]);
    bus(1'b0, vtc_pkg::REG_TRACE0, 32'h0);
    // Unmapped address reads zero
    rq.push_back(32'h0);
    bus(1'b0, 8'h20, 32'h0);
    {par, b3p, b3op, n1p, n1op, b3} = 48'h0;
    repeat (10) @(posedge lk);
    // One multiframe and the wrap into the next
    for (int k = 0; k < 77; k++) begin
      m = k % 76 + 1;
      cnt = $urandom_range(8);
      for (int p = 0; p < 765; p++) begin
        @(posedge lk);
        bt = $urandom;
        if (p == 0) begin
          pp = par;
          par = 8'h00;
        end
        if (p == 85) begin
          bt = pp ^ (8'hff >> (8 - cnt));
          b3 = bt;
        end
        if (p == 680) begin
          code = (cnt == 0) ? vtc_pkg::IEC_ZERO : 4'(cnt);
          iec = sf ? vtc_pkg::IEC_AIS : code;
          if (m <= 8) mfb = (m == 8) ? 2'b10 : 2'b11;
          else if (m <= 72) mfb = trace[127 - 2 * (m - 9) -: 2];
          else mfb = (m == 73) ? {1'b0, rdi} : (m == 74) ? {odi, 1'b0} : 2'b00;
          n1x = {iec, rei, oei, mfb};
          b3x = b3p ^ b3op ^ n1p ^ n1op ^ b3;
          note_q.push_back({n1x, b3x});
          {b3p, b3op, n1p, n1op} = {b3, b3x, bt, n1x};
        end
        // Indications change well clear of the overhead byte
        if (p == 700) begin
          sfn = ($urandom_range(3) == 0);
          rei <= 1'($urandom);
          oei <= 1'($urandom);
          rdi <= 1'($urandom);
          odi <= 1'($urandom);
          sf <= sfn;
          // Status seen at the last frame start: fail, count code, next frame
          if (k == 75) st = {19'h0, 1'b0, sfn, code, 7'((k + 1) % 76 + 1)};
        end
        fs <= (p == 0);
        d_in <= bt;
        par = par ^ bt;
      end
    end
    repeat (5) @(posedge lk);
    rq.push_back(st);
    bus(1'b0, vtc_pkg::REG_STATUS, 32'h0);
    repeat (3) @(posedge i_clk);
    wrap_up();
  end
endmodule : test_vtc_source
`default_nettype wire
